// ### common/ads_pkg.sv
// shared constants for the analog die status and stop register logic
package ads_pkg;
  // ******************************************************************
  // frame
  // ******************************************************************
  localparam int FRAME_BITS = 8;
  localparam int COND_COUNT = 8;
  // ******************************************************************
  // control byte layout
  // ******************************************************************
  localparam int CTL_SLOPE_TWO = 7;
  localparam int CTL_SLOPE_ONE = 6;
  localparam int CTL_PULLUP = 5;
  localparam int CTL_SW_THREE = 4;
  localparam int CTL_SW_TWO = 3;
  localparam int CTL_SW_ONE = 2;
  localparam int CTL_POWER_TWO = 1;
  localparam int CTL_POWER_ONE = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] STOP_PATTERN = 8'hC1;
  localparam logic [7:0] STOP_MASK = 8'hDF;
  // ******************************************************************
  // status byte layout
  // ******************************************************************
  localparam int STS_SOURCE = 7;
  localparam int STS_BUS = 6;
  localparam int STS_OVER = 5;
  localparam int STS_UNDER = 4;
  localparam int STS_HEAT = 3;
  localparam int STS_SWITCH = 2;
  localparam int STS_WAKE_TWO = 1;
  localparam int STS_WAKE_ONE = 0;
  // ******************************************************************
  // condition input vector positions
  // ******************************************************************
  localparam int CND_BUS_WAKE = 0;
  localparam int CND_BUS_FAULT = 1;
  localparam int CND_OVER = 2;
  localparam int CND_UNDER = 3;
  localparam int CND_HEAT = 4;
  localparam int CND_SWITCH = 5;
  localparam int CND_WAKE_ONE = 6;
  localparam int CND_WAKE_TWO = 7;
  typedef enum logic [1:0] {ADS_RUN, ADS_STOP_ARMED, ADS_STOP} ads_power_e;
endpackage : ads_pkg

// ### src/ads_spi_engine.sv
// byte-wide serial slave engine: pin synchronisers, shifting, frame checks
`timescale 1ns/1ps
module ads_spi_engine #(
  parameter int FRAME_BITS = ads_pkg::FRAME_BITS
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // serial pins
  input wire logic sclk_pin,
  input wire logic ss_n_pin,
  input wire logic mosi_pin,
  output logic miso_o,
  output logic miso_oe,
  // byte side
  input wire logic [7:0] tx_byte,
  output logic frame_start,
  output logic frame_end,
  output logic frame_valid,
  output logic [7:0] rx_byte
);
  localparam int CW = $clog2(FRAME_BITS + 2);
  localparam logic [CW-1:0] CNT_FULL = CW'(FRAME_BITS);
  localparam logic [CW-1:0] CNT_OVER = CW'(FRAME_BITS + 1);

  logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  logic ss_s1_reg, ss_s2_reg, ss_s3_reg;
  logic mosi_s1_reg, mosi_s2_reg;
  logic [CW-1:0] cnt_reg;
  logic [7:0] tx_shift_reg;
  logic [7:0] rx_shift_reg;
  logic miso_reg;

  wire sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
  wire sclk_fall = ~sclk_s2_reg & sclk_s3_reg;
  wire ss_fall = ~ss_s2_reg & ss_s3_reg;
  wire ss_rise = ss_s2_reg & ~ss_s3_reg;
  wire active = ~ss_s2_reg;

  // first stages feed only the second stages
  always_ff @(posedge clk) begin
    if (srst) begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      ss_s1_reg <= 1'b1;
      ss_s2_reg <= 1'b1;
      ss_s3_reg <= 1'b1;
      mosi_s1_reg <= 1'b0;
      mosi_s2_reg <= 1'b0;
    end else begin
      sclk_s1_reg <= sclk_pin;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      ss_s1_reg <= ss_n_pin;
      ss_s2_reg <= ss_s1_reg;
      ss_s3_reg <= ss_s2_reg;
      mosi_s1_reg <= mosi_pin;
      mosi_s2_reg <= mosi_s1_reg;
    end
  end

  // count saturates one past a full frame so longer frames stay invalid
  always_ff @(posedge clk) begin
    if (srst || ss_fall) begin
      cnt_reg <= '0;
    end else if (active && sclk_fall && cnt_reg != CNT_OVER) begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_shift_reg <= '0;
      rx_shift_reg <= '0;
      miso_reg <= 1'b0;
    end else if (ss_fall) begin
      tx_shift_reg <= tx_byte;
    end else if (active && sclk_rise) begin
      miso_reg <= tx_shift_reg[7];
      tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
    end else if (active && sclk_fall) begin
      rx_shift_reg <= {rx_shift_reg[6:0], mosi_s2_reg};
    end
  end

  assign frame_start = ss_fall;
  assign frame_end = ss_rise;
  assign frame_valid = ss_rise && cnt_reg == CNT_FULL;
  assign rx_byte = rx_shift_reg;
  assign miso_o = miso_reg;
  assign miso_oe = active;

  // last sampling edge may be counted in the cycle just before the select rise
  chk_frame_count: assert property (@(posedge clk) disable iff (srst)
    frame_valid |-> $past(active) && cnt_reg == CNT_FULL)
    else $error("valid frame without eight sampling edges");
endmodule : ads_spi_engine

// ### src/ads_status_stop.sv
// analog die status byte, fault latches, switch and bus gating, stop entry
`timescale 1ns/1ps
module ads_status_stop (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // serial pins
  input wire logic sclk_pin,
  input wire logic ss_n_pin,
  input wire logic mosi_pin,
  output logic miso_o,
  output logic miso_oe,
  // analog condition inputs, asynchronous
  input wire logic bus_wake_flag,
  input wire logic bus_fault_flag,
  input wire logic overvoltage_flag,
  input wire logic supply_fail_flag,
  input wire logic regulator_heat_warning,
  input wire logic switch_overheat,
  input wire logic wake_input_one,
  input wire logic wake_input_two,
  // controls to the analog die
  output logic bus_tx_enable,
  output logic [2:0] switch_enable_bits,
  output logic bus_pullup_select,
  output logic [1:0] bus_slope_bits,
  output logic [1:0] power_state_bits,
  output logic stop_mode
);
  // ******************************************************************
  // serial engine
  // ******************************************************************
  logic frame_start, frame_end, frame_valid;
  logic [7:0] rx_byte;
  logic [7:0] status_byte;

  ads_spi_engine #(.FRAME_BITS(ads_pkg::FRAME_BITS)) u_engine (
    .clk(clk),
    .srst(srst),
    .sclk_pin(sclk_pin),
    .ss_n_pin(ss_n_pin),
    .mosi_pin(mosi_pin),
    .miso_o(miso_o),
    .miso_oe(miso_oe),
    .tx_byte(status_byte),
    .frame_start(frame_start),
    .frame_end(frame_end),
    .frame_valid(frame_valid),
    .rx_byte(rx_byte)
  );

  // ******************************************************************
  // condition synchronisers
  // ******************************************************************
  localparam int N = ads_pkg::COND_COUNT;
  logic [N-1:0] cond_raw, cond_s1_reg, cond_reg, cond_prev_reg;
  assign cond_raw = {wake_input_two, wake_input_one, switch_overheat, regulator_heat_warning,
                     supply_fail_flag, overvoltage_flag, bus_fault_flag, bus_wake_flag};

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (srst) begin
          cond_s1_reg[gi] <= 1'b0;
          cond_reg[gi] <= 1'b0;
          cond_prev_reg[gi] <= 1'b0;
        end else begin
          cond_s1_reg[gi] <= cond_raw[gi];
          cond_reg[gi] <= cond_s1_reg[gi];
          cond_prev_reg[gi] <= cond_reg[gi];
        end
      end
    end
  endgenerate

  // ******************************************************************
  // power state and detector gating
  // ******************************************************************
  ads_pkg::ads_power_e pwr_reg, pwr_next;
  logic [7:0] ctrl_reg;
  wire in_stop = pwr_reg == ads_pkg::ADS_STOP;
  // supply and thermal detectors are off in stop
  wire run_det = ~in_stop;
  wire is_stop_byte = (rx_byte & ads_pkg::STOP_MASK) == ads_pkg::STOP_PATTERN;

  wire c_over = cond_reg[ads_pkg::CND_OVER] & run_det;
  wire c_under = cond_reg[ads_pkg::CND_UNDER] & run_det;
  wire c_heat = cond_reg[ads_pkg::CND_HEAT] & run_det;
  wire c_sw = cond_reg[ads_pkg::CND_SWITCH] & run_det;
  wire c_fault = cond_reg[ads_pkg::CND_BUS_FAULT];
  wire w_one = cond_reg[ads_pkg::CND_WAKE_ONE];
  wire w_two = cond_reg[ads_pkg::CND_WAKE_TWO];
  wire [N-1:0] rose = cond_reg & ~cond_prev_reg;
  wire [N-1:0] toggled = cond_reg ^ cond_prev_reg;
  wire bus_wake_evt = rose[ads_pkg::CND_BUS_WAKE];
  wire bus_fault_evt = rose[ads_pkg::CND_BUS_FAULT];
  wire wake_one_evt = in_stop & toggled[ads_pkg::CND_WAKE_ONE];
  wire wake_two_evt = in_stop & toggled[ads_pkg::CND_WAKE_TWO];
  // select rising edge also wakes from stop
  wire wake_evt = in_stop & (bus_wake_evt | wake_one_evt | wake_two_evt | frame_end);

  always_comb begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      ads_pkg::ADS_RUN: begin
        if (frame_valid && is_stop_byte) begin
          pwr_next = ads_pkg::ADS_STOP_ARMED;
        end
      end
      ads_pkg::ADS_STOP_ARMED: begin
        if (frame_valid) begin
          pwr_next = is_stop_byte ? ads_pkg::ADS_STOP : ads_pkg::ADS_RUN;
        end
      end
      ads_pkg::ADS_STOP: begin
        if (wake_evt) begin
          pwr_next = ads_pkg::ADS_RUN;
        end
      end
      default: pwr_next = ads_pkg::ADS_RUN;
    endcase
  end

  // ******************************************************************
  // flags and event source
  // ******************************************************************
  logic bus_flag_reg, sw_flag_reg, sw_off_reg, tx_off_reg, src_pend_reg, sw_seen_reg;
  logic [6:0] src_bits_reg;
  logic [6:0] live_bits, evt_bits;

  assign live_bits = {bus_flag_reg, c_over, c_under, c_heat, sw_flag_reg, w_two, w_one};
  assign evt_bits = {bus_wake_evt | bus_fault_evt, rose[ads_pkg::CND_OVER] & run_det,
                     rose[ads_pkg::CND_UNDER] & run_det, rose[ads_pkg::CND_HEAT] & run_det,
                     rose[ads_pkg::CND_SWITCH] & run_det, wake_two_evt, wake_one_evt};
  wire any_evt = |evt_bits;
  wire bus_set = bus_wake_evt | c_fault;
  wire rd_bus = frame_start & bus_flag_reg;
  wire rd_sw = frame_start & sw_flag_reg;

  // source byte replaces live bits for one read, or also the next if an event lands in the read's select-fall cycle
  assign status_byte = src_pend_reg ? {1'b1, src_bits_reg} : {1'b0, live_bits};

  always_ff @(posedge clk) begin
    if (srst) begin
      src_pend_reg <= 1'b0;
      src_bits_reg <= '0;
    end else if (any_evt) begin
      src_pend_reg <= 1'b1;
      src_bits_reg <= frame_start ? evt_bits : (src_bits_reg | evt_bits);
    end else if (frame_start) begin
      src_pend_reg <= 1'b0;
      src_bits_reg <= '0;
    end
  end

  // a set in the read cycle wins over the clear
  always_ff @(posedge clk) begin
    if (srst) begin
      bus_flag_reg <= 1'b0;
      sw_flag_reg <= 1'b0;
    end else begin
      bus_flag_reg <= bus_set | (bus_flag_reg & ~rd_bus);
      sw_flag_reg <= c_sw | (sw_flag_reg & ~rd_sw);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_off_reg <= 1'b0;
      sw_off_reg <= 1'b0;
      sw_seen_reg <= 1'b0;
    end else begin
      // flag state at select fall: the clearing read cannot also re-enable
      if (frame_start) begin
        sw_seen_reg <= sw_flag_reg;
      end
      if (c_fault) begin
        tx_off_reg <= 1'b1;
      end else if (!bus_flag_reg) begin
        tx_off_reg <= 1'b0;
      end
      if (c_sw) begin
        sw_off_reg <= 1'b1;
      end else if (frame_valid && !sw_flag_reg && !sw_seen_reg) begin
        sw_off_reg <= 1'b0;
      end
    end
  end

  // ******************************************************************
  // control register and outputs
  // ******************************************************************
  logic [2:0] sw_on_reg;
  logic tx_en_reg;
  wire [2:0] sw_req = {ctrl_reg[ads_pkg::CTL_SW_THREE], ctrl_reg[ads_pkg::CTL_SW_TWO],
                       ctrl_reg[ads_pkg::CTL_SW_ONE]};

  always_ff @(posedge clk) begin
    if (srst) begin
      pwr_reg <= ads_pkg::ADS_RUN;
      ctrl_reg <= ads_pkg::CTL_RESET;
      sw_on_reg <= '0;
      tx_en_reg <= 1'b0;
    end else begin
      pwr_reg <= pwr_next;
      if (frame_valid) begin
        ctrl_reg <= rx_byte;
      end
      sw_on_reg <= (sw_off_reg | c_sw | in_stop) ? 3'h0 : sw_req;
      tx_en_reg <= ~(tx_off_reg | c_fault);
    end
  end

  assign switch_enable_bits = sw_on_reg;
  assign bus_tx_enable = tx_en_reg;
  assign bus_pullup_select = ctrl_reg[ads_pkg::CTL_PULLUP];
  assign bus_slope_bits = {ctrl_reg[ads_pkg::CTL_SLOPE_TWO], ctrl_reg[ads_pkg::CTL_SLOPE_ONE]};
  assign power_state_bits = {ctrl_reg[ads_pkg::CTL_POWER_TWO], ctrl_reg[ads_pkg::CTL_POWER_ONE]};
  assign stop_mode = in_stop;

  // ******************************************************************
  // checks
  // ******************************************************************
  chk_live_status: assert property (@(posedge clk) disable iff (srst)
    frame_start && !src_pend_reg |-> status_byte == {1'b0, live_bits})
    else $error("live status byte wrong");
  chk_source_shown: assert property (@(posedge clk) disable iff (srst)
    frame_start && src_pend_reg |-> status_byte[ads_pkg::STS_SOURCE])
    else $error("pending source not reported");
  chk_source_once: assert property (@(posedge clk) disable iff (srst)
    frame_start && !any_evt |=> !src_pend_reg)
    else $error("source flag not cleared after read");
  chk_bus_clear: assert property (@(posedge clk) disable iff (srst)
    rd_bus && !bus_set |=> !bus_flag_reg)
    else $error("bus flag not cleared by read");
  chk_tx_disable: assert property (@(posedge clk) disable iff (srst)
    c_fault |=> !bus_tx_enable)
    else $error("transmitter not disabled on fault");
  chk_tx_reenable: assert property (@(posedge clk) disable iff (srst)
    $rose(bus_tx_enable) |-> $past(!c_fault, 1) && $past(!bus_flag_reg, 2))
    else $error("transmitter back too early");
  chk_switch_off: assert property (@(posedge clk) disable iff (srst)
    c_sw |=> (switch_enable_bits == 3'h0) [*2])
    else $error("switches not off on overheat");
  chk_stop_twice: assert property (@(posedge clk) disable iff (srst)
    $rose(stop_mode) |-> $past(pwr_reg) == ads_pkg::ADS_STOP_ARMED && $past(is_stop_byte))
    else $error("stop without two stop bytes");
  chk_ctrl_commit: assert property (@(posedge clk) disable iff (srst)
    frame_valid |=> ctrl_reg == $past(rx_byte))
    else $error("control byte not committed");
  cov_stop_entry: cover property (@(posedge clk) disable iff (srst) $rose(stop_mode));
  cov_wake_source: cover property (@(posedge clk) disable iff (srst)
    frame_start && src_pend_reg && (src_bits_reg[1] || src_bits_reg[0]));
  cov_switch_restore: cover property (@(posedge clk) disable iff (srst)
    $fell(sw_off_reg));
  cov_tx_restore: cover property (@(posedge clk) disable iff (srst) $rose(tx_off_reg) ##[1:1000]
    $fell(tx_off_reg));
endmodule : ads_status_stop

// ### verif/ads_spi_master.sv
// behavioural serial master driving the status and stop block
`timescale 1ns/1ps
module ads_spi_master (
  // serial pins
  output logic sclk_pin,
  output logic ss_n_pin,
  output logic mosi_pin,
  // reply
  input wire logic miso_o,
  input wire logic miso_oe
);
  // ******************************************************************
  // state
  // ******************************************************************
  // half period of the serial clock; the bench stretches it for slow frames
  int half_ns = 24;
  initial begin
    sclk_pin = 1'b0;
    ss_n_pin = 1'b1;
    mosi_pin = 1'b0;
  end
  // ******************************************************************
  // one framed transfer, edges normally eight
  // ******************************************************************
  task automatic xfer(input logic [7:0] tx, input int edges, output logic [7:0] rx);
    logic [15:0] sh;
    sh = {tx, 8'h00};
    rx = 8'h00;
    ss_n_pin = 1'b0;
    #(half_ns);
    for (int i = 0; i < edges; i++) begin
      sclk_pin = 1'b1;
      mosi_pin = sh[15];
      sh = sh << 1;
      #(half_ns);
      sclk_pin = 1'b0;
      // an undriven reply must never pass as data
      rx = {rx[6:0], (miso_oe === 1'b1) ? miso_o : 1'bx};
      #(half_ns);
    end
    ss_n_pin = 1'b1;
    // released line must not keep showing the last bit
    mosi_pin = ~mosi_pin;
    #60;
  endtask : xfer
endmodule : ads_spi_master

// ### verif/tb.sv
// self-checking bench for the status byte, fault latches and stop entry
`timescale 1ns/1ps
module tb;
  // ******************************************************************
  // signals
  // ******************************************************************
  logic clk;
  logic srst;
  logic [7:0] cond;
  logic [7:0] ctl;
  int fail_count = 0;
  int n_checks = 0;
  int sbit [6];
  wire sclk;
  wire ss_n;
  wire mosi;
  wire miso;
  wire oe;
  wire tx_en;
  wire [2:0] sw;
  wire pu;
  wire [1:0] slope;
  wire [1:0] pwr;
  wire stop;
  ads_status_stop uut (
    .clk(clk),
    .srst(srst),
    .sclk_pin(sclk),
    .ss_n_pin(ss_n),
    .mosi_pin(mosi),
    .miso_o(miso),
    .miso_oe(oe),
    .bus_wake_flag(cond[ads_pkg::CND_BUS_WAKE]),
    .bus_fault_flag(cond[ads_pkg::CND_BUS_FAULT]),
    .overvoltage_flag(cond[ads_pkg::CND_OVER]),
    .supply_fail_flag(cond[ads_pkg::CND_UNDER]),
    .regulator_heat_warning(cond[ads_pkg::CND_HEAT]),
    .switch_overheat(cond[ads_pkg::CND_SWITCH]),
    .wake_input_one(cond[ads_pkg::CND_WAKE_ONE]),
    .wake_input_two(cond[ads_pkg::CND_WAKE_TWO]),
    .bus_tx_enable(tx_en),
    .switch_enable_bits(sw),
    .bus_pullup_select(pu),
    .bus_slope_bits(slope),
    .power_state_bits(pwr),
    .stop_mode(stop)
  );
  ads_spi_master mst (
    .sclk_pin(sclk),
    .ss_n_pin(ss_n),
    .mosi_pin(mosi),
    .miso_o(miso),
    .miso_oe(oe)
  );
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ******************************************************************
  // tasks
  // ******************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  task automatic rd(input logic [7:0] exp);
    logic [7:0] r;
    mst.xfer(ctl, 8, r);
    check(r, exp);
  endtask : rd
  task automatic wr(input logic [7:0] b);
    logic [7:0] r;
    ctl = b;
    mst.xfer(ctl, 8, r);
  endtask : wr
  task automatic setc(input int i, input logic v);
    @(negedge clk);
    cond[i] = v;
    repeat (10) @(negedge clk);
  endtask : setc
  // ******************************************************************
  // tests
  // ******************************************************************
  initial begin
    logic [7:0] r;
    logic [7:0] b;
    cond = 8'h00;
    ctl = 8'h00;
    srst = 1'b1;
    sbit = '{ads_pkg::STS_BUS, ads_pkg::STS_BUS, ads_pkg::STS_OVER, ads_pkg::STS_UNDER,
             ads_pkg::STS_HEAT, ads_pkg::STS_SWITCH};
    repeat (2) @(posedge clk);
    @(negedge clk) srst = 1'b0;
    repeat (6) @(negedge clk);
    check({7'h00, tx_en}, 8'h01);
    check({7'h00, stop}, 8'h00);
    check({7'h00, oe}, 8'h00);
    rd(8'h00);
    wr(8'hA6);
    check({slope, pu, sw, pwr}, 8'hA6);
    mst.xfer(8'h00, 7, r);
    check({slope, pu, sw, pwr}, 8'hA6);
    mst.xfer(8'h00, 9, r);
    check({slope, pu, sw, pwr}, 8'hA6);
    // slow master still gets through
    mst.half_ns = 40;
    wr(8'h5A);
    check({slope, pu, sw, pwr}, 8'h5A);
    mst.half_ns = 24;
    ctl = 8'h00;
    for (int i = 0; i < 6; i++) begin
      b = 8'h01 << sbit[i];
      setc(i, 1'b1);
      if (i == 1) check({7'h00, tx_en}, 8'h00);
      if (i < 2) setc(i, 1'b0);
      if (i == 1) check({7'h00, tx_en}, 8'h00);
      rd(8'h80 | b);
      if (i == 1) check({7'h00, tx_en}, 8'h01);
      rd((i < 2) ? 8'h00 : b);
      setc(i, 1'b0);
      mst.xfer(ctl, 8, r);
      rd(8'h00);
    end
    // thermal shutdown and the two-step recovery
    wr(8'h1C);
    check({5'h00, sw}, 8'h07);
    setc(ads_pkg::CND_SWITCH, 1'b1);
    check({5'h00, sw}, 8'h00);
    setc(ads_pkg::CND_SWITCH, 1'b0);
    check({5'h00, sw}, 8'h00);
    // the clearing read itself carries the enables; switches must stay off
    ctl = 8'h1C;
    rd(8'h84);
    check({5'h00, sw}, 8'h00);
    wr(8'h1C);
    check({5'h00, sw}, 8'h07);
    // stop entry needs two stop bytes in a row
    wr(8'hC1);
    check({7'h00, stop}, 8'h00);
    wr(8'h1C);
    wr(8'hE1);
    check({7'h00, stop}, 8'h00);
    mst.xfer(8'h00, 7, r);
    wr(8'hC1);
    check({7'h00, stop}, 8'h01);
    setc(ads_pkg::CND_WAKE_ONE, 1'b1);
    check({7'h00, stop}, 8'h00);
    ctl = 8'h00;
    rd(8'h81);
    rd(8'h01);
    setc(ads_pkg::CND_WAKE_TWO, 1'b1);
    rd(8'h03);
    setc(ads_pkg::CND_WAKE_ONE, 1'b0);
    setc(ads_pkg::CND_WAKE_TWO, 1'b0);
    rd(8'h00);
    check({7'h00, oe}, 8'h00);
    final_report();
  end
  // ******************************************************************
  // watchdog, well beyond the roughly 20 us the tests need
  // ******************************************************************
  initial begin
    #200000;
    fail_count++;
    final_report();
  end
endmodule : tb
